// *** hw/aim_pkg.sv ***
package aim_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses on the apb slave)
  // ----------------------------------------------------------------------
  localparam logic [13:0] OFS_CTRL     = 14'h0000;
  localparam logic [13:0] OFS_DIAG     = 14'h0004;
  localparam logic [13:0] OFS_HSRC     = 14'h0008;
  localparam logic [13:0] OFS_STAT     = 14'h000C;
  localparam logic [13:0] OFS_HADDR    = 14'h0010;
  localparam logic [7:0]  CNT_PAGE     = 8'h01;     // paddr[13:6], counters at 0x40..0x74
  localparam logic [1:0]  HIST_PAGE0   = 2'h1;      // paddr[13:12], channel 0 words
  localparam logic [1:0]  HIST_PAGE1   = 2'h2;      // paddr[13:12], channel 1 words

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_TEST_BIT  = 14;
  localparam int unsigned CTRL_RST_BIT   = 15;
  localparam int unsigned DIAG_FRZ_PULSE = 14;
  localparam int unsigned DIAG_FRZ_SAMP  = 15;
  localparam logic [13:0] MASK_RST       = 14'h0000;
  localparam logic [15:0] DIAG_RST       = 16'h0000;
  localparam logic [7:0]  HSRC_RST       = 8'h00;

  // backplane trigger line positions (all active low)
  localparam int unsigned TRIG_SAMPLE    = 0;
  localparam int unsigned TRIG_CENTER    = 2;
  localparam int unsigned TRIG_GATE      = 3;
  localparam int unsigned TRIG_LEFT      = 5;
  localparam int unsigned TRIG_RIGHT     = 7;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam longint unsigned CLK_PERIOD_PS   = 4000;
  localparam longint unsigned SAMPLE_PERIOD_NS = 2000;
  localparam longint unsigned RST_PULSE_NS    = 1000;
  localparam longint unsigned BLINK_MS        = 50;
  localparam logic [8:0]  SAMPLE_LAST =
    9'(SAMPLE_PERIOD_NS * 1000 / CLK_PERIOD_PS - 1);
  localparam logic [7:0]  RST_PULSE_CYCLES =
    8'(RST_PULSE_NS * 1000 / CLK_PERIOD_PS);
  localparam int unsigned BLINK_CYCLES =
    32'(BLINK_MS * 64'h0000_0000_3B9A_CA00 / CLK_PERIOD_PS);
  localparam logic [9:0]  HIST_LAST = 10'h3FF;

  typedef enum logic [2:0] {
    HS_IDLE   = 3'b001,
    HS_REC    = 3'b010,
    HS_FROZEN = 3'b100
  } aim_hist_e;

endpackage

// *** hw/aim_top.sv ***
`timescale 1ns/100ps

// Functional notes
// - fourteen arc inputs, low means faulted
// - arc drops carrier and protection permits, holds
// - per-channel mask suppresses fault action but not arc led
// - sixteen-bit event counter per arc channel
// - counters run until software clears each one
// - flag raised when any counter bit 15 sets
// - test output faults arcs; reset pulse restores
// - low hard enable holds protection permit low
// - protection permit high ok, never read back
// - two diagnostic selectors decode channels 00-15
// - two history channels, 1024 words, selectable source
// - gate assertion restarts recording, 500 kHz samples
// - bit 15 plus sample pulse freezes after record
// - bit 14 freezes after next macropulse record
// - both bits set behaves like bit 14
// - select led follows selection; gate led green
// - arc led green all high, red blink otherwise
// - hard permit led follows hard enable input
// - permit led follows output; fault led on fault
// - switches choose left, centre, right or all carrier lines
// - gate is active-low trigger line 3, starts macropulse
module aim_top #(
  parameter int unsigned P_BLINK_CYCLES = aim_pkg::BLINK_CYCLES
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [13:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // pins, asynchronous
  input  wire logic [13:0] i_fiber_arc_input,
  input  wire logic [7:0]  i_trig_lines_n,
  input  wire logic        i_hard_rf_enable_in,
  input  wire logic        i_module_select,
  input  wire logic [1:0]  i_carrier_sel,
  // permits and arc chassis control
  output logic             o_carrier_permit_left,
  output logic             o_carrier_permit_center,
  output logic             o_carrier_permit_right,
  output logic             o_protection_permit_out,
  output logic             o_arc_test_out,
  output logic             o_arc_reset_out,
  // diagnostic selectors
  output logic [3:0]       o_diag_sel_a,
  output logic [3:0]       o_diag_sel_b,
  output logic             o_diag_level_a,
  output logic             o_diag_level_b,
  // front panel indicators
  output logic             o_module_selected_led,
  output logic             o_gate_led,
  output logic             o_arc_fault_led,
  output logic             o_hard_permit_led,
  output logic             o_permit_led,
  output logic             o_module_fault_led
);

  typedef struct packed {
    logic [25:0]       s1;
    logic [25:0]       s2;
    logic [13:0]       arc_d;
    logic              gate_d;
    logic              samp_d;
    logic [13:0]       mask;
    logic              test;
    logic [7:0]        rst_cnt;
    logic [15:0]       diag;
    logic [7:0]        hsrc;
    logic [13:0][15:0] cnt;
    logic              flag;
    logic              hold;
    aim_pkg::aim_hist_e hst;
    logic [9:0]        hwa;
    logic [8:0]        tick;
    logic              pend;
    logic [31:0]       blink;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [2:0]        cperm;
    logic              prot;
    logic              rst_out;
    logic [9:0]        leds;
  } aim_state_s;

  aim_state_s  r;
  aim_state_s  st_nxt;

  logic [15:0] hist_mem0 [0:1023];
  logic [15:0] hist_mem1 [0:1023];
  logic        hist_we;
  logic [15:0] hist_d0;
  logic [15:0] hist_d1;
  logic [13:0] arc_evt;
  logic [13:0] cnt_clr;

  // ----------------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic diag_level(input logic [3:0] sel, input logic bank_b,
                                      input logic [7:0] trig_n, input logic [13:0] arc);
    logic [3:0] k;
    k = sel - 4'h9;
    if (sel == 4'h0)
      return 1'b0;
    else if (sel <= 4'h8)
      return bank_b ? 1'b0 : trig_n[3'(sel - 4'h1)];
    else
      return arc[4'(k + (bank_b ? 4'h7 : 4'h0))];
  endfunction

  function automatic logic [15:0] hist_pick(input logic [3:0] sel,
                                            input logic [13:0][15:0] cnt,
                                            input logic [25:0] pins);
    if (sel < 4'hE)
      return cnt[sel];
    else if (sel == 4'hE)
      return {2'b00, pins[13:0]};
    else
      return {7'h00, pins[22:14]};
  endfunction

  function automatic logic [2:0] carrier_line(input logic [1:0] sw);
    unique case (sw)
      2'b00:   return 3'b100;
      2'b01:   return 3'b010;
      2'b10:   return 3'b001;
      default: return 3'b111;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [13:0] arc_ok;
    logic [7:0]  trig_n;
    logic        hard;
    logic        gate_on;
    logic        samp_on;
    logic        gate_rise;
    logic        acc;
    logic        take;
    logic        hit;
    logic [31:0] rd;
    logic [3:0]  cidx;
    logic        is_cnt;
    logic        bp_flt;
    logic        frz;
    arc_ok    = r.s2[13:0];
    trig_n    = r.s2[21:14];
    hard      = r.s2[22];
    gate_on   = !trig_n[aim_pkg::TRIG_GATE];
    samp_on   = !trig_n[aim_pkg::TRIG_SAMPLE];
    gate_rise = gate_on & !r.gate_d;
    acc       = i_psel & i_penable;
    take      = acc & r.pready;
    cidx      = i_paddr[5:2];
    is_cnt    = (i_paddr[13:6] == aim_pkg::CNT_PAGE) && (cidx < 4'hE);
    bp_flt    = !trig_n[aim_pkg::TRIG_LEFT] | !trig_n[aim_pkg::TRIG_CENTER]
              | !trig_n[aim_pkg::TRIG_RIGHT];
    frz       = 1'b0;
    hist_we   = 1'b0;
    hist_d0   = hist_pick(r.hsrc[3:0], r.cnt, r.s2);
    hist_d1   = hist_pick(r.hsrc[7:4], r.cnt, r.s2);

    st_nxt        = r;
    // second flop of each synchroniser is the only reader of the first
    st_nxt.s1     = {i_carrier_sel, i_module_select, i_hard_rf_enable_in,
                     i_trig_lines_n, i_fiber_arc_input};
    st_nxt.s2     = r.s1;
    st_nxt.arc_d  = arc_ok;
    st_nxt.gate_d = gate_on;
    st_nxt.samp_d = samp_on;

    // ---------------------------------------------------------------------
    // arc faults and permits
    // ---------------------------------------------------------------------
    arc_evt     = r.arc_d & ~arc_ok & ~r.mask;
    // hold lasts while faulted, and while the macropulse is still open
    st_nxt.hold = (|(~arc_ok & ~r.mask)) | (r.hold & gate_on);
    st_nxt.cperm = ~(carrier_line(r.s2[25:24]) & {3{st_nxt.hold}});
    // output is only driven; its wire level is never looked at
    st_nxt.prot = !st_nxt.hold & hard & !bp_flt;

    // ---------------------------------------------------------------------
    // apb slave: one wait state, data and write land on the pready edge
    // ---------------------------------------------------------------------
    hit = 1'b1;
    rd  = 32'h0000_0000;
    if (is_cnt)
      rd = {16'h0000, r.cnt[cidx]};
    else if (i_paddr[13:12] == aim_pkg::HIST_PAGE0)
      rd = {16'h0000, hist_mem0[i_paddr[11:2]]};
    else if (i_paddr[13:12] == aim_pkg::HIST_PAGE1)
      rd = {16'h0000, hist_mem1[i_paddr[11:2]]};
    else if (i_paddr == aim_pkg::OFS_CTRL)
      rd = {16'h0000, r.rst_out, r.test, r.mask};
    else if (i_paddr == aim_pkg::OFS_DIAG)
      rd = {16'h0000, r.diag};
    else if (i_paddr == aim_pkg::OFS_HSRC)
      rd = {24'h00_0000, r.hsrc};
    else if (i_paddr == aim_pkg::OFS_STAT)
      rd = {12'h000, r.hst == aim_pkg::HS_FROZEN, r.hst == aim_pkg::HS_REC,
            r.flag, r.hold, hard, gate_on, arc_ok};
    else if (i_paddr == aim_pkg::OFS_HADDR)
      rd = {22'h00_0000, r.hwa};
    else
      hit = 1'b0;
    if (i_pwrite && i_paddr[13:12] != 2'h0)
      hit = 1'b0;
    st_nxt.pready  = acc & !r.pready;
    st_nxt.pslverr = acc & !r.pready & !hit;
    st_nxt.prdata  = (acc & !r.pready & !i_pwrite & hit) ? rd : 32'h0000_0000;

    if (take && i_pwrite && i_paddr == aim_pkg::OFS_CTRL) begin
      st_nxt.mask = i_pwdata[13:0];
      st_nxt.test = i_pwdata[aim_pkg::CTRL_TEST_BIT];
    end
    if (take && i_pwrite && i_paddr == aim_pkg::OFS_DIAG)
      st_nxt.diag = i_pwdata[15:0];
    if (take && i_pwrite && i_paddr == aim_pkg::OFS_HSRC)
      st_nxt.hsrc = i_pwdata[7:0];

    // arc reset is a timed pulse so the chassis sees a clean command
    if (take && i_pwrite && i_paddr == aim_pkg::OFS_CTRL && i_pwdata[aim_pkg::CTRL_RST_BIT])
      st_nxt.rst_cnt = aim_pkg::RST_PULSE_CYCLES;
    else if (r.rst_cnt != 8'h00)
      st_nxt.rst_cnt = r.rst_cnt - 8'h01;
    st_nxt.rst_out = (st_nxt.rst_cnt != 8'h00);

    // ---------------------------------------------------------------------
    // event counters: an arc in the clearing cycle counts as one
    // ---------------------------------------------------------------------
    for (int i = 0; i < 14; i++) begin
      cnt_clr[i] = take & i_pwrite & is_cnt & (cidx == 4'(i));
      if (arc_evt[i])
        st_nxt.cnt[i] = cnt_clr[i] ? 16'h0001 : r.cnt[i] + 16'h0001;
      else if (cnt_clr[i])
        st_nxt.cnt[i] = 16'h0000;
    end
    st_nxt.flag = 1'b0;
    for (int i = 0; i < 14; i++)
      st_nxt.flag = st_nxt.flag | st_nxt.cnt[i][15];

    // ---------------------------------------------------------------------
    // history buffer
    // ---------------------------------------------------------------------
    if (!r.diag[aim_pkg::DIAG_FRZ_SAMP])
      st_nxt.pend = 1'b0;
    else if (samp_on & !r.samp_d)
      st_nxt.pend = 1'b1;
    unique case (r.hst)
      aim_pkg::HS_IDLE: begin
        if (gate_rise) begin
          st_nxt.hst  = aim_pkg::HS_REC;
          st_nxt.hwa  = 10'h000;
          st_nxt.tick = 9'h000;
        end
      end
      aim_pkg::HS_REC: begin
        if (gate_rise) begin
          st_nxt.hwa  = 10'h000;
          st_nxt.tick = 9'h000;
        end else begin
          st_nxt.tick = (r.tick == aim_pkg::SAMPLE_LAST) ? 9'h000 : r.tick + 9'h001;
          if (r.tick == 9'h000) begin
            hist_we = 1'b1;
            // bit 14 wins when both are set
            frz = r.diag[aim_pkg::DIAG_FRZ_PULSE] | st_nxt.pend;
            if (r.hwa == aim_pkg::HIST_LAST) begin
              st_nxt.hst  = frz ? aim_pkg::HS_FROZEN : aim_pkg::HS_IDLE;
              st_nxt.pend = 1'b0;
            end else
              st_nxt.hwa = r.hwa + 10'h001;
          end
        end
      end
      aim_pkg::HS_FROZEN: begin
        if (!r.diag[aim_pkg::DIAG_FRZ_PULSE] && !r.diag[aim_pkg::DIAG_FRZ_SAMP])
          st_nxt.hst = aim_pkg::HS_IDLE;
      end
      default: st_nxt.hst = aim_pkg::HS_IDLE;
    endcase

    // ---------------------------------------------------------------------
    // indicators; blink stretches a 100 us arc into a visible flash
    // ---------------------------------------------------------------------
    if (!(&arc_ok))
      st_nxt.blink = P_BLINK_CYCLES;
    else if (r.blink != 32'h0000_0000)
      st_nxt.blink = r.blink - 32'h0000_0001;
    st_nxt.leds = {
      diag_level(r.diag[3:0], 1'b0, trig_n, arc_ok),
      diag_level(r.diag[7:4], 1'b1, trig_n, arc_ok),
      r.s2[23],
      gate_on,
      (st_nxt.blink != 32'h0000_0000),
      hard,
      st_nxt.prot,
      st_nxt.hold,
      2'b00
    };
  end

  // ----------------------------------------------------------------------
  // state registers and buffer memory
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      r         <= '0;
      r.s1      <= 26'h3FF_FFFF;
      r.s2      <= 26'h3FF_FFFF;
      r.arc_d   <= 14'h3FFF;
      r.mask    <= aim_pkg::MASK_RST;
      r.diag    <= aim_pkg::DIAG_RST;
      r.hsrc    <= aim_pkg::HSRC_RST;
      r.hst     <= aim_pkg::HS_IDLE;
      r.cperm   <= 3'h7;
    end else begin
      r <= st_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (hist_we) begin
      hist_mem0[r.hwa] <= hist_d0;
      hist_mem1[r.hwa] <= hist_d1;
    end
  end

  assign o_pready                = r.pready;
  assign o_prdata                = r.prdata;
  assign o_pslverr               = r.pslverr;
  assign o_carrier_permit_left   = r.cperm[2];
  assign o_carrier_permit_center = r.cperm[1];
  assign o_carrier_permit_right  = r.cperm[0];
  assign o_protection_permit_out = r.prot;
  assign o_arc_test_out          = r.test;
  assign o_arc_reset_out         = r.rst_out;
  assign o_diag_sel_a            = r.diag[3:0];
  assign o_diag_sel_b            = r.diag[7:4];
  assign o_diag_level_a          = r.leds[9];
  assign o_diag_level_b          = r.leds[8];
  assign o_module_selected_led   = r.leds[7];
  assign o_gate_led              = r.leds[6];
  assign o_arc_fault_led         = r.leds[5];
  assign o_hard_permit_led       = r.leds[4];
  assign o_permit_led            = r.leds[3];
  assign o_module_fault_led      = r.leds[2];

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence arc_seen;
    |(~r.s2[13:0] & ~r.mask);
  endsequence

  chk_arc_drops_permit: assert property (arc_seen |=> !o_protection_permit_out && r.hold)
    else $error("arc did not drop protection permit");
  chk_hold_in_gate: assert property (r.hold && !r.s2[17] |=> r.hold)
    else $error("arc hold released inside macropulse");
  chk_mask_quiet: assert property ((&r.mask) && !r.hold |=> !r.hold)
    else $error("masked channels raised a fault");
  chk_count_step: assert property (arc_evt[0] && !cnt_clr[0]
                                   |=> r.cnt[0] == $past(r.cnt[0]) + 16'h0001)
    else $error("counter did not step on arc");
  chk_flag_follow: assert property (r.cnt[3][15] |-> r.flag)
    else $error("overflow flag missing");
  chk_hard_permit: assert property (!r.s2[22] |=> !o_protection_permit_out)
    else $error("hard enable fault did not drop permit");
  chk_reset_pulse: assert property ($rose(o_arc_reset_out) |-> o_arc_reset_out[*8])
    else $error("arc reset pulse too short");
  chk_hist_start: assert property (r.s2[17] ##1 !r.s2[17] && r.hst != aim_pkg::HS_FROZEN
                                   |=> r.hst == aim_pkg::HS_REC && r.hwa == 10'h000)
    else $error("history did not restart at zero");
  chk_freeze_kept: assert property (r.hst == aim_pkg::HS_FROZEN && r.diag[15:14] != 2'b00
                                    |=> r.hst == aim_pkg::HS_FROZEN)
    else $error("frozen buffer released early");
  chk_left_line: assert property (arc_seen && r.s2[25:24] == 2'b00 |=> !o_carrier_permit_left)
    else $error("left carrier line not dropped");

endmodule

// *** tb/aim_far_model.sv ***
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// arc chassis and vacuum controller stand-in
// ----------------------------------------------------------------------
module aim_far_model (
  // commands from the bench
  input  wire logic        i_ref_clk,
  input  wire logic [13:0] i_arc_cmd,
  input  wire logic        i_vac_ok,
  // chassis controls from the device
  input  wire logic        i_arc_test_out,
  input  wire logic        i_arc_reset_out,
  // pins toward the device
  output logic [13:0]      o_fiber_arc_input,
  output logic             o_hard_rf_enable_in
);
  logic lamp_r = 1'b0;

  // lamp test stays latched after release until the reset pulse comes
  always @(posedge i_ref_clk) begin
    if (i_arc_test_out) begin
      lamp_r <= 1'b1;
    end else if (i_arc_reset_out) begin
      lamp_r <= 1'b0;
    end
  end

  assign o_fiber_arc_input   = lamp_r ? 14'h0000 : ~i_arc_cmd;
  assign o_hard_rf_enable_in = i_vac_ok;
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps

module tb_top;
  logic        i_ref_clk = 1'b0;
  logic        i_reset   = 1'b1;
  logic        i_psel    = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite  = 1'b0;
  logic [13:0] i_paddr   = 14'h0000;
  logic [31:0] i_pwdata  = 32'h0000_0000;
  logic [13:0] arc_cmd   = 14'h0000;
  logic        vac_ok    = 1'b1;
  logic [7:0]  i_trig_lines_n  = 8'hFF;
  logic        i_module_select = 1'b0;
  logic [1:0]  i_carrier_sel   = 2'b00;
  logic        o_pready, o_pslverr, o_arc_test_out, o_arc_reset_out;
  logic [31:0] o_prdata, rdat;
  logic [13:0] i_fiber_arc_input;
  logic        i_hard_rf_enable_in, rerr, o_diag_level_a, o_diag_level_b;
  logic        o_carrier_permit_left, o_carrier_permit_center, o_carrier_permit_right;
  logic        o_protection_permit_out, o_module_selected_led, o_gate_led;
  logic        o_arc_fault_led, o_hard_permit_led, o_permit_led, o_module_fault_led;
  logic [3:0]  o_diag_sel_a, o_diag_sel_b;
  int          mismatches = 0;
  int          n_checks   = 0;
  int          npulse;

  always #2 i_ref_clk = ~i_ref_clk;

  aim_top #(.P_BLINK_CYCLES(20)) aim_top_inst (.i_ref_clk, .i_reset, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_fiber_arc_input,
    .i_trig_lines_n, .i_hard_rf_enable_in, .i_module_select, .i_carrier_sel,
    .o_carrier_permit_left, .o_carrier_permit_center, .o_carrier_permit_right,
    .o_protection_permit_out, .o_arc_test_out, .o_arc_reset_out, .o_diag_sel_a,
    .o_diag_sel_b, .o_diag_level_a, .o_diag_level_b, .o_module_selected_led, .o_gate_led,
    .o_arc_fault_led, .o_hard_permit_led, .o_permit_led, .o_module_fault_led);

  aim_far_model aim_far_model_inst (.i_ref_clk, .i_arc_cmd(arc_cmd), .i_vac_ok(vac_ok),
    .i_arc_test_out(o_arc_test_out), .i_arc_reset_out(o_arc_reset_out),
    .o_fiber_arc_input(i_fiber_arc_input), .o_hard_rf_enable_in(i_hard_rf_enable_in));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
    end while (o_pready !== 1'b1);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (6) @(posedge i_ref_clk);
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    settle();
    apb(1'b0, aim_pkg::OFS_DIAG, 32'h0);
    check(rdat, 32'(aim_pkg::DIAG_RST));
    apb(1'b0, aim_pkg::OFS_HSRC, 32'h0);
    check(rdat, 32'(aim_pkg::HSRC_RST));
    apb(1'b0, 14'h0020, 32'h0);
    check(32'(rerr), 32'h1);
    check(32'(o_protection_permit_out), 32'h1);
    // unmasked arc drops the left line and the protection permit
    arc_cmd <= 14'h0001;
    settle();
    check({o_protection_permit_out, o_carrier_permit_left, o_carrier_permit_center}, 3'b001);
    check({o_module_fault_led, o_arc_fault_led, o_permit_led}, 3'b110);
    check({o_carrier_permit_center, o_carrier_permit_right}, 2'b11);
    arc_cmd <= 14'h0000;
    settle();
    check({o_protection_permit_out, o_carrier_permit_left}, 2'b11);
    apb(1'b0, 14'h0040, 32'h0);
    check(rdat, 32'h1);
    // masked channel takes no action and is not counted
    apb(1'b1, aim_pkg::OFS_CTRL, 32'h0000_3FFF);
    arc_cmd <= 14'h3FFF;
    settle();
    check(32'(o_protection_permit_out), 32'h1);
    check(32'(o_module_fault_led), 32'h0);
    arc_cmd <= 14'h0000;
    apb(1'b0, 14'h0044, 32'h0);
    check(rdat, 32'h0);
    apb(1'b1, aim_pkg::OFS_CTRL, 32'h0000_0002);
    // hold lasts until the gate releases, on the centre line
    i_carrier_sel  <= 2'b01;
    i_trig_lines_n <= 8'hF7;
    settle();
    check(32'(o_gate_led), 32'h1);
    arc_cmd <= 14'h0004;
    settle();
    arc_cmd <= 14'h0000;
    settle();
    check({o_protection_permit_out, o_carrier_permit_center, o_carrier_permit_left}, 3'b001);
    i_trig_lines_n <= 8'hFF;
    settle();
    check({o_protection_permit_out, o_carrier_permit_center}, 2'b11);
    // hard enable fault
    vac_ok <= 1'b0;
    settle();
    check({o_protection_permit_out, o_hard_permit_led}, 2'b00);
    vac_ok <= 1'b1;
    settle();
    check({o_protection_permit_out, o_hard_permit_led}, 2'b11);
    // counters clear one at a time
    apb(1'b1, 14'h0040, 32'h0);
    apb(1'b0, 14'h0040, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, 14'h0048, 32'h0);
    check(rdat, 32'h1);
    // diagnostic selectors: A on gate line, B on arc channel 07
    apb(1'b1, aim_pkg::OFS_DIAG, 32'h0000_0094);
    apb(1'b1, aim_pkg::OFS_HSRC, 32'h0000_000E);
    i_trig_lines_n  <= 8'hF7;
    i_module_select <= 1'b1;
    settle();
    check({o_diag_sel_a, o_diag_sel_b}, 8'h49);
    check({o_diag_level_a, o_diag_level_b, o_module_selected_led}, 3'b011);
    // recording, hard ok, gate on, every arc line idle
    apb(1'b0, aim_pkg::OFS_STAT, 32'h0);
    check(rdat, 32'h0004_FFFF);
    // word 0 of channel 0 holds the arc lines taken at gate assertion
    apb(1'b0, 14'h1000, 32'h0);
    check(rdat, 32'h0000_3FFF);
    i_trig_lines_n <= 8'hFF;
    // lamp test faults every channel, reset pulse restores
    apb(1'b1, aim_pkg::OFS_CTRL, 32'h0000_4000);
    settle();
    check({o_arc_test_out, o_protection_permit_out}, 2'b10);
    apb(1'b1, aim_pkg::OFS_CTRL, 32'h0000_0000);
    apb(1'b1, aim_pkg::OFS_CTRL, 32'h0000_8000);
    npulse = 0;
    repeat (400) begin
      @(posedge i_ref_clk);
      npulse += int'(o_arc_reset_out === 1'b1);
    end
    check(32'(npulse), 32'(aim_pkg::RST_PULSE_CYCLES));
    check(32'(o_protection_permit_out), 32'h1);
    apb(1'b0, 14'h0044, 32'h0);
    check(rdat, 32'h1);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
